// ==== cpu_exception_sequencer.sv ====
`default_nettype none
// Operation
// - normal cycle end only on transfer_ack; cycle stays open otherwise
// - transfer_error_ack alone ends cycle and starts error exception
// - both acks together retry the failed cycle
// - locked or serialized pending work finishes before exception entry
// - entry runs four steps; bus cycle order may differ
// - step one copies status, sets supervisor, clears both trace bits
// - reset and interrupt also rewrite the priority mask
// - interrupts take vector by acknowledge cycle; others internally
// - after reset prefetch, execution starts at program counter
// - reset touches no caches and stacks nothing
// - fault during reset entry halts with state outputs at 5
// - software reset instruction never starts a reset exception
// - six-word return restores status, pc, adds C to stack pointer
// - frame: status, pc at 02, format and vector at 06, address 08
// - address error stacks faulting pc and referenced address minus one
// - inexact decimal flag only set by software writes
// - maskable fp exception when execution sets an enabled bit
// - software writes to flags or enables never trigger exceptions
// - nan, operand, overflow, underflow also raise nonmaskable trap
// - only highest-priority enabled fp exception is reported
// - enable byte priority falls from bit 15 down to bit 8
// - acknowledge cycle: wait, spurious, vector, autovector or retry
module cpu_exception_sequencer
	import exc_seq_pkg::*;
(
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// bus termination
	input  wire logic          transfer_ack,
	input  wire logic          transfer_error_ack,
	input  wire logic          autovector_request,
	input  wire logic [7:0]    bus_data,
	// core requests
	input  wire logic          bus_cycle_start,
	input  wire logic          fault_address_error,
	input  wire logic [31:0]   fault_address,
	input  wire logic          exc_request,
	input  wire exc_seq_pkg::exc_kind_e exc_kind,
	input  wire logic [7:0]    exc_vector,
	input  wire logic [2:0]    irq_level,
	input  wire logic          locked_pending,
	input  wire logic          reset_insn,
	input  wire logic          rte_request,
	input  wire exc_seq_pkg::frame_s rte_frame,
	input  wire logic [31:0]   current_pc,
	input  wire logic [31:0]   reset_pc,
	input  wire logic [31:0]   ssp_in,
	input  wire logic [15:0]   status_in,
	// floating point
	input  wire logic          fp_exec_valid,
	input  wire logic [7:0]    fp_exec_flags,
	input  wire logic          fp_sw_write,
	input  wire logic [7:0]    fp_sw_flags,
	input  wire logic [7:0]    fp_control_word,
	// bus cycle results
	output logic               cycle_done,
	output logic               cycle_retry,
	output logic               bus_in_cycle,
	output logic               iack_cycle,
	// exception entry
	output logic [15:0]        status_word,
	output logic [15:0]        status_copy,
	output logic [7:0]         vector_number,
	output exc_seq_pkg::frame_s frame_out,
	output logic               frame_valid,
	output logic               exec_start,
	output logic [31:0]        program_counter,
	output logic [31:0]        ssp_out,
	output logic [3:0]         processor_state_outputs,
	output logic               halted,
	// floating point results
	output logic [7:0]         fp_exception_byte,
	output logic               fp_trap,
	output logic               fp_nonmask_trap,
	output logic [2:0]         fp_trap_index
);
	import exc_seq_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN    = 3'b000,
		ST_DRAIN  = 3'b001,
		ST_STEP1  = 3'b010,
		ST_VECTOR = 3'b011,
		ST_STACK  = 3'b100,
		ST_FETCH  = 3'b101,
		ST_HALT   = 3'b110
	} seq_state_e;

	typedef struct packed {
		seq_state_e  st;
		exc_kind_e   kind;
		logic        in_cycle;
		logic        done;
		logic        retry;
		logic [7:0]  vec;
		logic [2:0]  lvl;
		logic [15:0] sw;
		logic [15:0] sw_copy;
		logic [31:0] pc;
		logic [31:0] ssp;
		logic [31:0] addr;
		frame_s      frame;
		logic        fvalid;
		logic        start;
		logic [3:0]  pst;
		logic [7:0]  fpx;
		logic        trap;
		logic        nmtrap;
		logic [2:0]  tidx;
	} seq_s;

	seq_s state_ff;
	seq_s nxt_state;

	logic       prio_hit;
	logic [2:0] prio_index;
	logic [7:0] fp_new;

	// inexact decimal never set by execution
	assign fp_new = fp_exec_flags & ~8'(1 << FP_INEXACT_DECIMAL_INPUT_FLAG);

	fp_exc_prio #(
		.BITS(8)
	) u_prio (
		.raised (fp_new),
		.enabled(fp_control_word),
		.hit    (prio_hit),
		.index  (prio_index)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_state        = state_ff;
		nxt_state.done   = 1'b0;
		nxt_state.retry  = 1'b0;
		nxt_state.fvalid = 1'b0;
		nxt_state.start  = 1'b0;
		nxt_state.trap   = 1'b0;
		nxt_state.nmtrap = 1'b0;

		// fp flags: software writes latch but never trap
		if (fp_sw_write) begin
			nxt_state.fpx = fp_sw_flags;
		end
		if (fp_exec_valid) begin
			// execution bits stack on a same-cycle software write
			nxt_state.fpx = nxt_state.fpx | fp_new;
			// only execution-set bits are checked, not stale ones
			if (prio_hit) begin
				nxt_state.trap = 1'b1;
				nxt_state.tidx = prio_index;
			end
			nxt_state.nmtrap = fp_new[FP_SIGNALING_NAN_FLAG] | fp_new[FP_OPERAND_ERROR_FLAG]
				| fp_new[FP_OVERFLOW_FLAG] | fp_new[FP_UNDERFLOW_FLAG];
		end

		// bus cycle tracking
		if (bus_cycle_start && state_ff.st != ST_HALT) begin
			nxt_state.in_cycle = 1'b1;
		end

		unique case (state_ff.st)
			ST_RUN: begin
				if (state_ff.in_cycle) begin
					if (transfer_ack && transfer_error_ack) begin
						nxt_state.retry = 1'b1;
					end else if (transfer_ack) begin
						nxt_state.in_cycle = 1'b0;
						nxt_state.done     = 1'b1;
					end else if (transfer_error_ack) begin
						nxt_state.in_cycle = 1'b0;
						nxt_state.kind     = EK_BUSER;
						nxt_state.vec      = VEC_BUS_ERR;
						nxt_state.st       = ST_DRAIN;
					end
				end else if (rte_request
					&& rte_frame.fmt_vec[15:12] == FRAME_FMT_SIX) begin
					nxt_state.sw  = rte_frame.sw;
					nxt_state.pc  = rte_frame.pc;
					nxt_state.ssp = ssp_in + FRAME_SIX_BYTES;
					nxt_state.start = 1'b1;
				end else if (exc_request && exc_kind != EK_NONE
					&& !(exc_kind == EK_RESET && reset_insn)) begin
					nxt_state.kind = exc_kind;
					nxt_state.vec  = exc_kind == EK_ADDR ? VEC_ADDR_ERR
						: exc_vector;
					nxt_state.lvl  = irq_level;
					nxt_state.addr = fault_address - 32'h1;
					nxt_state.st   = ST_DRAIN;
				end
			end
			// hold off entry while locked work remains
			ST_DRAIN: begin
				if (!locked_pending) begin
					nxt_state.st = ST_STEP1;
				end
			end
			// step one: copy, supervisor, trace off, mask
			ST_STEP1: begin
				nxt_state.sw_copy = state_ff.kind == EK_RESET
					? status_in : state_ff.sw;
				nxt_state.sw[SW_SUPER_BIT]    = 1'b1;
				nxt_state.sw[SW_TRACE_HI_BIT] = 1'b0;
				nxt_state.sw[SW_TRACE_LO_BIT] = 1'b0;
				if (state_ff.kind == EK_RESET) begin
					nxt_state.sw[SW_MASK_LSB +: SW_MASK_W] = 3'b111;
				end else if (state_ff.kind == EK_IRQ) begin
					nxt_state.sw[SW_MASK_LSB +: SW_MASK_W] = state_ff.lvl;
				end
				nxt_state.pst = PST_EXC;
				nxt_state.st  = state_ff.kind == EK_IRQ
					? ST_VECTOR : ST_STACK;
				nxt_state.in_cycle = state_ff.kind == EK_IRQ;
			end
			// interrupt acknowledge termination
			ST_VECTOR: begin
				if (transfer_ack && transfer_error_ack) begin
					nxt_state.retry = 1'b1;
				end else if (transfer_ack) begin
					nxt_state.in_cycle = 1'b0;
					nxt_state.vec = autovector_request ? bus_data
						: VEC_AUTO0 + 8'(state_ff.lvl);
					nxt_state.st  = ST_STACK;
				end else if (transfer_error_ack) begin
					nxt_state.in_cycle = 1'b0;
					nxt_state.vec = VEC_SPURIOUS;
					nxt_state.st  = ST_STACK;
				end
			end
			// reset stacks nothing, others emit the frame
			ST_STACK: begin
				if (state_ff.kind == EK_RESET) begin
					nxt_state.pc       = reset_pc;
					nxt_state.in_cycle = 1'b1;
					nxt_state.st       = ST_FETCH;
				end else begin
					nxt_state.frame.sw      = state_ff.sw_copy;
					nxt_state.frame.pc      = current_pc;
					nxt_state.frame.fmt_vec = {FRAME_FMT_SIX, 2'b00,
						state_ff.vec, 2'b00};
					nxt_state.frame.addr    = state_ff.addr;
					nxt_state.fvalid = 1'b1;
					nxt_state.ssp    = ssp_in - FRAME_SIX_BYTES;
					nxt_state.pst    = PST_NORMAL;
					nxt_state.start  = 1'b1;
					nxt_state.st     = ST_RUN;
				end
			end
			// reset prefetch; a fault here is a double bus fault
			ST_FETCH: begin
				if (fault_address_error
					|| (transfer_error_ack && !transfer_ack)) begin
					nxt_state.pst = PST_HALT;
					nxt_state.in_cycle = 1'b0;
					nxt_state.st  = ST_HALT;
				end else if (transfer_ack && !transfer_error_ack) begin
					nxt_state.in_cycle = 1'b0;
					nxt_state.pst   = PST_NORMAL;
					nxt_state.start = 1'b1;
					nxt_state.st    = ST_RUN;
				end else if (transfer_ack && transfer_error_ack) begin
					nxt_state.retry = 1'b1;
				end
			end
			// only an external reset leaves halt
			ST_HALT: begin
				nxt_state.in_cycle = 1'b0;
			end
			default: nxt_state.st = ST_HALT;
		endcase
	end

	// ------------------------------------------------------------
	// register; reset enters the reset exception
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_ff      <= '0;
			state_ff.st   <= ST_STEP1;
			state_ff.kind <= EK_RESET;
			state_ff.vec  <= VEC_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign cycle_done              = state_ff.done;
	assign cycle_retry             = state_ff.retry;
	assign bus_in_cycle            = state_ff.in_cycle;
	assign iack_cycle              = state_ff.st == ST_VECTOR;
	assign status_word             = state_ff.sw;
	assign status_copy             = state_ff.sw_copy;
	assign vector_number           = state_ff.vec;
	assign frame_out               = state_ff.frame;
	assign frame_valid             = state_ff.fvalid;
	assign exec_start              = state_ff.start;
	assign program_counter         = state_ff.pc;
	assign ssp_out                 = state_ff.ssp;
	assign processor_state_outputs = state_ff.pst;
	assign halted                  = state_ff.st == ST_HALT;
	assign fp_exception_byte       = state_ff.fpx;
	assign fp_trap                 = state_ff.trap;
	assign fp_nonmask_trap         = state_ff.nmtrap;
	assign fp_trap_index           = state_ff.tidx;
endmodule : cpu_exception_sequencer
`default_nettype wire

// ==== exc_seq_pkg.sv ====
`default_nettype none
package exc_seq_pkg;

	// ------------------------------------------------------------
	// status word layout
	// ------------------------------------------------------------
	localparam int SW_TRACE_HI_BIT = 15;
	localparam int SW_TRACE_LO_BIT = 14;
	localparam int SW_SUPER_BIT    = 13;
	localparam int SW_MASK_LSB     = 8;
	localparam int SW_MASK_W       = 3;

	// ------------------------------------------------------------
	// processor state output codes
	// ------------------------------------------------------------
	localparam logic [3:0] PST_NORMAL = 4'h0;
	localparam logic [3:0] PST_EXC    = 4'hC;
	localparam logic [3:0] PST_HALT   = 4'h5;

	// ------------------------------------------------------------
	// six-word frame
	// ------------------------------------------------------------
	localparam logic [3:0]  FRAME_FMT_SIX   = 4'h2;
	localparam logic [31:0] FRAME_SIX_BYTES = 32'h0000000C;
	localparam logic [7:0]  OFF_SW          = 8'h00;
	localparam logic [7:0]  OFF_PC          = 8'h02;
	localparam logic [7:0]  OFF_FMT_VEC     = 8'h06;
	localparam logic [7:0]  OFF_ADDR        = 8'h08;

	// ------------------------------------------------------------
	// vector numbers (decimal)
	// ------------------------------------------------------------
	localparam logic [7:0] VEC_RESET    = 8'd0;
	localparam logic [7:0] VEC_BUS_ERR  = 8'd2;
	localparam logic [7:0] VEC_ADDR_ERR = 8'd3;
	localparam logic [7:0] VEC_SPURIOUS = 8'd24;
	localparam logic [7:0] VEC_AUTO0    = 8'd24;
	localparam logic [7:0] VEC_FP_BASE  = 8'd48;

	// ------------------------------------------------------------
	// exception kinds, enable byte positions (bit 15 = index 7)
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		EK_NONE  = 3'b000,
		EK_RESET = 3'b001,
		EK_IRQ   = 3'b010,
		EK_BUSER = 3'b011,
		EK_ADDR  = 3'b100,
		EK_OTHER = 3'b101
	} exc_kind_e;

	localparam int FP_SIGNALING_NAN_FLAG  = 6;
	localparam int FP_OPERAND_ERROR_FLAG = 5;
	localparam int FP_OVERFLOW_FLAG  = 4;
	localparam int FP_UNDERFLOW_FLAG  = 3;
	localparam int FP_INEXACT_DECIMAL_INPUT_FLAG = 0;

	// bus termination pair
	typedef struct packed {
		logic ack;
		logic err;
	} bus_term_s;

	// frame words presented for stacking
	typedef struct packed {
		logic [15:0] sw;
		logic [31:0] pc;
		logic [15:0] fmt_vec;
		logic [31:0] addr;
	} frame_s;

endpackage : exc_seq_pkg
`default_nettype wire

// ==== fp_exc_prio.sv ====
`default_nettype none
module fp_exc_prio
	import exc_seq_pkg::*;
#(
	parameter int BITS = 8
) (
	// exception and enable bytes
	input  wire logic [BITS-1:0] raised,
	input  wire logic [BITS-1:0] enabled,
	// winner
	output logic                 hit,
	output logic [2:0]           index
);
	// the 3-bit index only serves an eight-bit enable byte
	if (BITS != 8) begin : g_bits_chk
		$error("fp_exc_prio: BITS must be 8");
	end

	// ------------------------------------------------------------
	// highest bit wins; lower ones are dropped
	// ------------------------------------------------------------
	always_comb begin
		hit   = 1'b0;
		index = 3'd0;
		for (int i = 0; i < BITS; i++) begin
			if (raised[i] && enabled[i]) begin
				hit   = 1'b1;
				index = 3'(i);
			end
		end
	end
endmodule : fp_exc_prio
`default_nettype wire

// ==== cpu_exception_sequencer_properties.sv ====
`default_nettype none
module cpu_exception_sequencer_properties
	import exc_seq_pkg::*;
(
	// clock and reset
	input wire logic                clk_sys,
	input wire logic                rst_n,
	// bus side
	input wire logic                transfer_ack,
	input wire logic                transfer_error_ack,
	input wire logic                bus_in_cycle,
	input wire logic                iack_cycle,
	input wire logic                cycle_done,
	input wire logic                cycle_retry,
	// exception entry
	input wire logic                exec_start,
	input wire logic                halted,
	input wire logic [3:0]          processor_state_outputs,
	input wire logic                frame_valid,
	input wire exc_seq_pkg::frame_s frame_out,
	input wire logic [7:0]          vector_number,
	input wire logic [15:0]         status_word,
	input wire logic [31:0]         ssp_in,
	input wire logic [31:0]         ssp_out,
	// floating point
	input wire logic                fp_exec_valid,
	input wire logic [7:0]          fp_exec_flags,
	input wire logic [7:0]          fp_control_word,
	input wire logic                fp_sw_write,
	input wire logic                fp_trap,
	input wire logic [2:0]          fp_trap_index,
	input wire logic                fp_nonmask_trap,
	input wire logic [7:0]          fp_exception_byte
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// enabled flags kept as a signal so $past sees a plain name
	logic [7:0] fp_hit;
	assign fp_hit = fp_exec_flags & fp_control_word;
	// highest set bit wins, index 7 stands for enable bit 15
	function automatic logic [2:0] top_bit(input logic [7:0] v);
		top_bit = 3'h0;
		for (int i = 0; i < 8; i++)
			if (v[i])
				top_bit = i[2:0];
	endfunction : top_bit
	sequence ack_alone;
		bus_in_cycle & ~iack_cycle & transfer_ack & ~transfer_error_ack;
	endsequence
	sequence err_alone;
		bus_in_cycle & transfer_error_ack & ~transfer_ack;
	endsequence
	sequence halt_held;
		processor_state_outputs == PST_HALT ##1 halted & ~exec_start;
	endsequence
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	done_by_ack_a: assert property (cycle_done |->
		$past(transfer_ack) & ~$past(transfer_error_ack))
		else $error("cycle ended without acknowledge");
	ack_closes_a: assert property (ack_alone |=> cycle_done | exec_start)
		else $error("acknowledged cycle not closed");
	retry_both_a: assert property (
		bus_in_cycle & transfer_ack & transfer_error_ack
		|=> cycle_retry & ~cycle_done) else $error("both acks gave no retry");
	err_ends_a: assert property (
		err_alone |=> ~cycle_done ##[0:8] (frame_valid | halted))
		else $error("error ack started no exception");
	step_one_a: assert property (frame_valid |-> status_word[SW_SUPER_BIT]
		& ~status_word[SW_TRACE_HI_BIT] & ~status_word[SW_TRACE_LO_BIT])
		else $error("entry status bits wrong");
	halt_code_a: assert property (halted |-> halt_held)
		else $error("halt code or hold wrong");
	frame_form_a: assert property (frame_valid |-> ssp_out ==
		ssp_in - FRAME_SIX_BYTES && frame_out.fmt_vec ==
		{FRAME_FMT_SIX, 2'b00, vector_number, 2'b00})
		else $error("stack frame malformed");
	fp_cause_a: assert property (fp_trap |-> $past(fp_exec_valid) &&
		fp_trap_index == top_bit($past(fp_hit)))
		else $error("fp trap cause or priority wrong");
	fp_sw_quiet_a: assert property (fp_sw_write & ~fp_exec_valid
		|=> ~fp_trap) else $error("software write raised fp trap");
	nonmask_a: assert property (fp_exec_valid &
		|fp_exec_flags[FP_SIGNALING_NAN_FLAG:FP_UNDERFLOW_FLAG] |=> fp_nonmask_trap)
		else $error("nonmaskable fp trap missing");
	inex_sw_a: assert property ($rose(fp_exception_byte[FP_INEXACT_DECIMAL_INPUT_FLAG])
		|-> $past(fp_sw_write)) else $error("decimal flag set by core");
endmodule : cpu_exception_sequencer_properties
bind cpu_exception_sequencer cpu_exception_sequencer_properties u_props (
	.clk_sys, .rst_n, .transfer_ack, .transfer_error_ack, .bus_in_cycle,
	.iack_cycle, .cycle_done, .cycle_retry, .exec_start, .halted,
	.processor_state_outputs, .frame_valid, .frame_out, .vector_number,
	.status_word, .ssp_in, .ssp_out, .fp_exec_valid, .fp_exec_flags,
	.fp_control_word, .fp_sw_write, .fp_trap, .fp_trap_index,
	.fp_nonmask_trap, .fp_exception_byte
);
`default_nettype wire

// ==== bus_responder_model.sv ====
`default_nettype none
module bus_responder_model #(
	parameter logic [3:0] LIMIT = 4'h6
) (
	// clock, reset, cycle state
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       bus_in_cycle,
	input  wire logic       iack_cycle,
	// behaviour: 0 ack, 1 error, 2 retry then ack, 3 silent until LIMIT then error
	input  wire logic [1:0] mode,
	input  wire logic [3:0] delay,
	input  wire logic [7:0] vec,
	input  wire logic       av,
	// terminations
	output logic            transfer_ack,
	output logic            transfer_error_ack,
	output logic            autovector_request,
	output logic [7:0]      bus_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// responder
	// ------------------------------------------------------------
	logic [3:0] cnt_ff;
	logic       tried_ff;
	logic       busy;
	logic       term;
	assign busy = bus_in_cycle | iack_cycle;
	assign term = transfer_ack | transfer_error_ack;
	// one-cycle answers; idle data toggles since nothing holds it
	always_ff @(posedge clk_sys) begin
		transfer_ack <= 1'b0;
		transfer_error_ack <= 1'b0;
		bus_data <= ~bus_data;
		autovector_request <= ~autovector_request;
		cnt_ff <= busy ? cnt_ff + 4'h1 : 4'h0;
		if (!busy)
			tried_ff <= 1'b0;
		if (!rst_n) begin
			cnt_ff <= 4'h0;
			tried_ff <= 1'b0;
			bus_data <= 8'h00;
			autovector_request <= 1'b1;
		end else if (busy && !term && mode == 2'd3) begin
			if (cnt_ff == LIMIT)
				transfer_error_ack <= 1'b1;
		end else if (busy && !term && cnt_ff >= delay) begin
			cnt_ff <= 4'h0;
			transfer_ack <= mode != 2'd1;
			transfer_error_ack <= mode == 2'd1 || (mode == 2'd2 && !tried_ff);
			tried_ff <= mode == 2'd2;
			bus_data <= vec;
			autovector_request <= av;
		end
	end
endmodule : bus_responder_model
`default_nettype wire

// ==== cpu_exception_sequencer_tb.sv ====
`default_nettype none
module cpu_exception_sequencer_tb
	import exc_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk_sys = 1'b0, rst_n = 1'b0, av = 1'b1;
	logic transfer_ack, transfer_error_ack, autovector_request;
	logic bus_cycle_start, fault_address_error, exc_request, locked_pending;
	logic reset_insn, rte_request, fp_exec_valid, fp_sw_write;
	logic [7:0] bus_data, exc_vector, fp_exec_flags, fp_sw_flags;
	logic [7:0] fp_control_word, vector_number, fp_exception_byte;
	logic [31:0] fault_address, current_pc, reset_pc, ssp_in;
	logic [31:0] program_counter, ssp_out;
	logic [15:0] status_in, status_word, status_copy;
	logic [3:0] processor_state_outputs, delay;
	logic [2:0] irq_level, fp_trap_index;
	logic [1:0] mode;
	exc_kind_e exc_kind;
	frame_s rte_frame, frame_out;
	logic cycle_done, cycle_retry, bus_in_cycle, iack_cycle, frame_valid;
	logic exec_start, halted, fp_trap, fp_nonmask_trap;
	int miscompares = 0, cmp_count = 0;
	logic [6:0] ev;
	assign ev = {program_counter === rte_frame.pc, halted, fp_trap,
		exec_start, frame_valid, cycle_retry, cycle_done};
	always #20 clk_sys = ~clk_sys;
	cpu_exception_sequencer dut (.clk_sys, .rst_n, .transfer_ack,
		.transfer_error_ack, .autovector_request, .bus_data, .bus_cycle_start,
		.fault_address_error, .fault_address, .exc_request, .exc_kind,
		.exc_vector, .irq_level, .locked_pending, .reset_insn, .rte_request,
		.rte_frame, .current_pc, .reset_pc, .ssp_in, .status_in,
		.fp_exec_valid, .fp_exec_flags, .fp_sw_write, .fp_sw_flags,
		.fp_control_word, .cycle_done, .cycle_retry, .bus_in_cycle,
		.iack_cycle, .status_word, .status_copy, .vector_number, .frame_out,
		.frame_valid, .exec_start, .program_counter, .ssp_out,
		.processor_state_outputs, .halted, .fp_exception_byte, .fp_trap,
		.fp_nonmask_trap, .fp_trap_index);
	bus_responder_model far (.clk_sys, .rst_n, .bus_in_cycle, .iack_cycle,
		.mode, .delay, .vec(8'h40), .av, .transfer_ack, .transfer_error_ack,
		.autovector_request, .bus_data);
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// bounded wait on one event bit; running out ends the run
	task automatic wt(input int b);
		int n;
		n = 0;
		while (ev[b] !== 1'b1 && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
		if (ev[b] !== 1'b1) begin
			miscompares++;
			print_verdict();
		end
	endtask : wt
	task automatic quiet(input int b, input int n);
		repeat (n) begin
			@(negedge clk_sys);
			chk(ev[b], 1'b0);
		end
	endtask : quiet
	// extra edge first, so the sequencer is back in its run state
	task automatic req(input exc_kind_e k);
		@(negedge clk_sys);
		exc_kind = k;
		exc_request = 1'b1;
		@(negedge clk_sys);
		exc_request = 1'b0;
	endtask : req
	task automatic strt();
		bus_cycle_start = 1'b1;
		@(negedge clk_sys);
		bus_cycle_start = 1'b0;
	endtask : strt
	task automatic rst();
		rst_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
	endtask : rst
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	// ------------------------------------------------------------
	// sequence of tests
	// ------------------------------------------------------------
	initial begin
		{bus_cycle_start, fault_address_error, exc_request} = 3'b000;
		{locked_pending, reset_insn, rte_request} = 3'b000;
		{fp_exec_valid, fp_sw_write, fp_sw_flags, fp_exec_flags} = '0;
		fp_control_word = 8'hFF;
		exc_kind = EK_NONE;
		exc_vector = 8'h77;
		irq_level = 3'h5;
		status_in = 16'hA700;
		rte_frame = '{16'h2015, 32'h00000888, 16'h2000, 32'h0};
		fault_address = 32'h00001000;
		current_pc = 32'h00000400;
		reset_pc = 32'h00000100;
		ssp_in = 32'h00008000;
		mode = 2'd0;
		delay = 4'h1;
		rst();
		wt(3);
		chk(program_counter, reset_pc);
		chk(status_copy, status_in);
		chk(status_word[15:13], 3'b001);
		chk(status_word[10:8], 3'h7);
		$display("test reset entry done");
		delay = 4'h3;
		strt();
		chk(bus_in_cycle, 1'b1);
		wt(0);
		chk(ev[1:0], 2'b01);
		mode = 2'd2;
		strt();
		wt(1);
		wt(0);
		chk(cycle_done, 1'b1);
		$display("test bus terminations done");
		mode = 2'd0;
		locked_pending = 1'b1;
		req(EK_ADDR);
		quiet(2, 6);
		locked_pending = 1'b0;
		wt(2);
		chk(frame_out.addr, fault_address - 32'h1);
		chk(frame_out.pc, current_pc);
		chk(vector_number, VEC_ADDR_ERR);
		chk(ssp_out, ssp_in - 32'hC);
		chk(status_copy, 16'h2700);
		chk(frame_out.sw, 16'h2700);
		chk(frame_out.fmt_vec, 16'h200C);
		chk(status_word[10:8], 3'h7);
		mode = 2'd3;
		strt();
		wt(2);
		chk(vector_number, VEC_BUS_ERR);
		$display("test internal vectors done");
		for (int i = 0; i < 4; i++) begin
			mode = i == 2 ? 2'd1 : i == 3 ? 2'd2 : 2'd0;
			av = i != 1;
			req(EK_IRQ);
			wt(2);
			chk(vector_number, i == 1 ? VEC_AUTO0 + 8'd5 :
				i == 2 ? VEC_SPURIOUS : 8'h40);
			chk(status_word[10:8], irq_level);
			chk({iack_cycle, bus_in_cycle}, 2'b00);
		end
		$display("test interrupt acknowledge done");
		rte_request = 1'b1;
		@(negedge clk_sys);
		rte_request = 1'b0;
		wt(6);
		chk(status_word, rte_frame.sw);
		chk(ssp_out, ssp_in + 32'hC);
		$display("test return done");
		for (int i = 0; i < 3; i++) begin
			fp_exec_flags = i == 0 ? 8'h58 : i == 1 ? 8'h83 : 8'h11;
			fp_control_word = i == 0 ? 8'hFF : i == 1 ? 8'h03 : 8'h11;
			fp_exec_valid = 1'b1;
			@(negedge clk_sys);
			fp_exec_valid = 1'b0;
			wt(4);
			chk(fp_trap_index, i == 0 ? 3'h6 : i == 1 ? 3'h1 : 3'h4);
			chk(fp_nonmask_trap, i != 1);
		end
		fp_control_word = 8'h00;
		fp_sw_flags = 8'hFF;
		fp_sw_write = 1'b1;
		@(negedge clk_sys);
		fp_sw_write = 1'b0;
		fp_control_word = 8'hFF;
		quiet(4, 4);
		chk(fp_exception_byte[FP_INEXACT_DECIMAL_INPUT_FLAG], 1'b1);
		$display("test floating point done");
		reset_insn = 1'b1;
		req(EK_RESET);
		quiet(3, 8);
		chk(processor_state_outputs, PST_NORMAL);
		mode = 2'd1;
		rst();
		wt(5);
		chk(processor_state_outputs, PST_HALT);
		quiet(3, 4);
		$display("test halt done");
		print_verdict();
	end
endmodule : cpu_exception_sequencer_tb
`default_nettype wire
